// ---- core/serial_transmitter_path.sv ----
// Function
// - Parity bit is the exclusive-or of all sent data bits.
// - Odd parity inverts that result; even parity sends it unchanged.
// - Parity bit sits after the last data bit, before the first stop.
// - While transmit is enabled the block drives the serial output pin.
// - Synchronous mode shifts on the sync clock pin; only master mode takes that pin over.
// - Writing the data buffer register starts a transmission.
// - Buffer moves to shifter when idle or right after the last stop bit.
// - A loaded frame goes out at the divisor, double speed or sync rate.
// - Unused upper bits are dropped for characters under eight bits.
// - Buffer-empty flag is set while the buffer is empty, clear otherwise.
// - Buffer-empty interrupt requested while enabled and flag stays set.
// - A data buffer write clears the buffer-empty flag.
// - Transmit-done sets when the frame is out and the buffer is empty.
// - Transmit-done clears on interrupt service or on writing one.
// - Transmit-done interrupt requested when enabled and the flag sets.
// - Frame: low start, data LSB first, optional parity, one/two stops.
// - Bit clock divides baud output by 16, 8 or 2 by mode.
// - Parity only when the upper parity mode bit is one.
// - Disable waits until shifter and buffer are empty, then pin released.
`timescale 1ns/1ps
module serial_transmitter_path
   import serial_tx_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register bus
   input wire av_req_t av_req,
   output av_rsp_t av_rsp,
   // Interrupt controller
   input wire logic global_irq_enable,
   input wire logic tx_done_serviced,
   output logic irq_buffer_empty,
   output logic irq_transmit_done,
   // Pins
   input wire logic xck_in,
   output pin_out_t pins
);

   typedef struct packed {
      tx_state_t st;
      logic [CHAR_W-1:0] buf_data;
      logic buf_full;
      logic [CHAR_W-1:0] shift;
      logic [3:0] bitcnt;
      logic par;
      logic tx_done;
      logic tx_en;
      logic ninth;
      logic be_ie;
      logic td_ie;
      logic double_speed;
      logic [2:0] size;
      logic par_odd;
      logic par_en;
      logic stop2;
      logic sync;
      logic master;
      logic [DIV_W-1:0] divisor;
      logic div_load;
      logic xs1;
      logic xs2;
      logic xs3;
      logic irq_be;
      logic irq_td;
      pin_out_t pins;
      av_rsp_t rsp;
   } core_state_t;

   core_state_t r_reg;
   core_state_t r_next;

   logic div_tick;
   logic div_xck;
   logic buf_parity;
   logic bit_en;
   logic wr_go;
   logic rd_take;
   logic [DATA_W-1:0] rd_word;

   tx_bit_clock #(
      .DW(DIV_W)
   ) u_bit_clock (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .divisor(r_reg.divisor),
      .reload(r_reg.div_load),
      .sync_mode(r_reg.sync),
      .double_speed(r_reg.double_speed),
      .bit_tick(div_tick),
      .xck_level(div_xck)
   );

   tx_parity u_parity (
      .data(r_reg.buf_data),
      .size(r_reg.size),
      .odd(r_reg.par_odd),
      .parity(buf_parity)
   );

   assign bit_en = (r_reg.sync && !r_reg.master) ? (r_reg.xs2 & ~r_reg.xs3) : div_tick;

   // A write is taken in the cycle in which waitrequest is low, a read in the cycle before.
   assign wr_go = av_req.write & ~r_reg.rsp.waitrequest;
   assign rd_take = av_req.read & r_reg.rsp.waitrequest;

   // Read word assembled one cycle ahead so it stands when waitrequest drops.
   always_comb begin
      rd_word = '0;
      case (av_req.address)
         OFS_STATUS_A: begin
            rd_word[SA_BUF_EMPTY] = ~r_reg.buf_full;
            rd_word[SA_TX_DONE] = r_reg.tx_done;
            rd_word[SA_DOUBLE] = r_reg.double_speed;
            rd_word[SA_BUSY] = (r_reg.st != ST_IDLE);
         end
         OFS_CONTROL_B: begin
            rd_word[CB_TX_EN] = r_reg.tx_en;
            rd_word[CB_NINTH] = r_reg.ninth;
            rd_word[CB_BE_IE] = r_reg.be_ie;
            rd_word[CB_TD_IE] = r_reg.td_ie;
         end
         OFS_CONTROL_C: begin
            rd_word[CC_SIZE_LO +: 3] = r_reg.size;
            rd_word[CC_PAR_ODD] = r_reg.par_odd;
            rd_word[CC_PAR_EN] = r_reg.par_en;
            rd_word[CC_STOP2] = r_reg.stop2;
            rd_word[CC_SYNC] = r_reg.sync;
            rd_word[CC_MASTER] = r_reg.master;
         end
         OFS_BAUD: begin
            rd_word[DIV_W-1:0] = r_reg.divisor;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   always_comb begin
      r_next = r_reg;
      r_next.div_load = 1'b0;

      // Two-stage synchroniser, then an edge stage.
      r_next.xs1 = xck_in;
      r_next.xs2 = r_reg.xs1;
      r_next.xs3 = r_reg.xs2;

      // Bus handshake: each request sees exactly one low waitrequest cycle.
      r_next.rsp.waitrequest = ~((av_req.read | av_req.write) & r_reg.rsp.waitrequest);
      if (rd_take) begin
         r_next.rsp.readdata = rd_word;
      end

      if (tx_done_serviced) begin
         r_next.tx_done = 1'b0;
      end

      if (wr_go) begin
         case (av_req.address)
            OFS_STATUS_A: begin
               if (av_req.writedata[SA_TX_DONE]) begin
                  r_next.tx_done = 1'b0;
               end
               r_next.double_speed = av_req.writedata[SA_DOUBLE];
            end
            OFS_CONTROL_B: begin
               r_next.tx_en = av_req.writedata[CB_TX_EN];
               r_next.ninth = av_req.writedata[CB_NINTH];
               r_next.be_ie = av_req.writedata[CB_BE_IE];
               r_next.td_ie = av_req.writedata[CB_TD_IE];
            end
            OFS_CONTROL_C: begin
               r_next.size = av_req.writedata[CC_SIZE_LO +: 3];
               r_next.par_odd = av_req.writedata[CC_PAR_ODD];
               r_next.par_en = av_req.writedata[CC_PAR_EN];
               r_next.stop2 = av_req.writedata[CC_STOP2];
               r_next.sync = av_req.writedata[CC_SYNC];
               r_next.master = av_req.writedata[CC_MASTER];
            end
            OFS_BAUD: begin
               r_next.divisor = av_req.writedata[DIV_W-1:0];
               r_next.div_load = 1'b1;
            end
            default: begin
               r_next.div_load = 1'b0;
            end
         endcase
      end

      // Frame sequencer, stepped once per bit period.
      if (bit_en) begin
         case (r_reg.st)
            ST_IDLE: begin
               if (r_reg.buf_full) begin
                  r_next.shift = r_reg.buf_data;
                  r_next.par = buf_parity;
                  r_next.buf_full = 1'b0;
                  r_next.st = ST_START;
               end
            end
            ST_START: begin
               r_next.bitcnt = 4'h0;
               r_next.st = ST_DATA;
            end
            ST_DATA: begin
               r_next.shift = {1'b0, r_reg.shift[CHAR_W-1:1]};
               if (r_reg.bitcnt == char_last(r_reg.size)) begin
                  r_next.st = r_reg.par_en ? ST_PARITY : ST_STOP1;
               end else begin
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
               end
            end
            ST_PARITY: begin
               r_next.st = ST_STOP1;
            end
            ST_STOP1, ST_STOP2: begin
               if (r_reg.st == ST_STOP1 && r_reg.stop2) begin
                  r_next.st = ST_STOP2;
               end else if (r_reg.buf_full) begin
                  r_next.shift = r_reg.buf_data;
                  r_next.par = buf_parity;
                  r_next.buf_full = 1'b0;
                  r_next.st = ST_START;
               end else begin
                  r_next.tx_done = 1'b1;
                  r_next.st = ST_IDLE;
               end
            end
            default: begin
               r_next.st = ST_IDLE;
            end
         endcase
      end

      // A write in the same cycle as a load refills the buffer, so no data is lost.
      // Writes are dropped while the transmitter neither is enabled nor owns the pin.
      if (wr_go && av_req.address == OFS_DATA && (r_reg.tx_en || r_reg.pins.txd_oe)) begin
         r_next.buf_data = {r_reg.ninth, av_req.writedata[7:0]} & char_mask(r_reg.size);
         r_next.buf_full = 1'b1;
      end

      r_next.pins.txd_oe = r_next.tx_en | (r_next.st != ST_IDLE) | r_next.buf_full;
      case (r_next.st)
         ST_START: r_next.pins.txd = 1'b0;
         ST_DATA: r_next.pins.txd = r_next.shift[0];
         ST_PARITY: r_next.pins.txd = r_next.par;
         default: r_next.pins.txd = 1'b1;
      endcase

      r_next.pins.xck_oe = r_next.sync & r_next.master;
      r_next.pins.sync_clock_pin = r_next.pins.xck_oe & div_xck;

      r_next.irq_be = r_next.be_ie & global_irq_enable & ~r_next.buf_full;
      r_next.irq_td = r_next.td_ie & global_irq_enable & r_next.tx_done;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.st <= ST_IDLE;
         r_reg.size <= SIZE_RESET;
         r_reg.divisor <= BAUD_RESET;
         r_reg.pins.txd <= 1'b1;
         r_reg.rsp.waitrequest <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign av_rsp = r_reg.rsp;
   assign pins = r_reg.pins;
   assign irq_buffer_empty = r_reg.irq_be;
   assign irq_transmit_done = r_reg.irq_td;

endmodule : serial_transmitter_path

// ---- core/serial_tx_pkg.sv ----
package serial_tx_pkg;

   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int DIV_W = 12;
   localparam int CHAR_W = 9;

   // Register byte offsets, one 32-bit word each.
   localparam logic [ADDR_W-1:0] OFS_DATA = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS_A = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_C = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_BAUD = 5'h10;

   // Status A fields.
   localparam int SA_BUF_EMPTY = 0;
   localparam int SA_TX_DONE = 1;
   localparam int SA_DOUBLE = 2;
   localparam int SA_BUSY = 3;
   // Control B fields.
   localparam int CB_TX_EN = 0;
   localparam int CB_NINTH = 1;
   localparam int CB_BE_IE = 2;
   localparam int CB_TD_IE = 3;
   // Control C fields.
   localparam int CC_SIZE_LO = 0;
   localparam int CC_PAR_ODD = 3;
   localparam int CC_PAR_EN = 4;
   localparam int CC_STOP2 = 5;
   localparam int CC_SYNC = 6;
   localparam int CC_MASTER = 7;

   // Character size codes.
   localparam logic [2:0] SIZE_5 = 3'h0;
   localparam logic [2:0] SIZE_6 = 3'h1;
   localparam logic [2:0] SIZE_7 = 3'h2;
   localparam logic [2:0] SIZE_8 = 3'h3;
   localparam logic [2:0] SIZE_9 = 3'h7;

   // Last phase of the bit divider: divide by 16, 8 and 2.
   localparam logic [3:0] PH_NORMAL_LAST = 4'hF;
   localparam logic [3:0] PH_DOUBLE_LAST = 4'h7;
   localparam logic [3:0] PH_SYNC_LAST = 4'h1;

   localparam logic [DIV_W-1:0] BAUD_RESET = 12'h000;
   localparam logic [2:0] SIZE_RESET = SIZE_8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2
   } tx_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } av_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] readdata;
      logic waitrequest;
   } av_rsp_t;

   typedef struct packed {
      logic txd;
      logic txd_oe;
      logic sync_clock_pin;
      logic xck_oe;
   } pin_out_t;

   function automatic logic [CHAR_W-1:0] char_mask(input logic [2:0] size);
      case (size)
         SIZE_5: char_mask = 9'h01F;
         SIZE_6: char_mask = 9'h03F;
         SIZE_7: char_mask = 9'h07F;
         SIZE_9: char_mask = 9'h1FF;
         default: char_mask = 9'h0FF;
      endcase
   endfunction : char_mask

   function automatic logic [3:0] char_last(input logic [2:0] size);
      case (size)
         SIZE_5: char_last = 4'h4;
         SIZE_6: char_last = 4'h5;
         SIZE_7: char_last = 4'h6;
         SIZE_9: char_last = 4'h8;
         default: char_last = 4'h7;
      endcase
   endfunction : char_last

endpackage : serial_tx_pkg

// ---- core/tx_bit_clock.sv ----
`timescale 1ns/1ps
module tx_bit_clock
   import serial_tx_pkg::*;
#(
   parameter int DW = DIV_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Setup
   input wire logic [DW-1:0] divisor,
   input wire logic reload,
   input wire logic sync_mode,
   input wire logic double_speed,
   // Timing out
   output logic bit_tick,
   output logic xck_level
);

   typedef struct packed {
      logic [DW-1:0] cnt;
      logic [3:0] phase;
      logic sync_clock_pin;
   } clk_state_t;

   clk_state_t r_reg;
   clk_state_t r_next;
   logic baud;
   logic [3:0] last;

   assign last = sync_mode ? PH_SYNC_LAST : (double_speed ? PH_DOUBLE_LAST : PH_NORMAL_LAST);
   assign baud = (r_reg.cnt == '0);
   assign bit_tick = baud & (r_reg.phase == last) & ~reload;
   // Taken from the next state, so the registered pin rises on the edge that starts a bit.
   assign xck_level = r_next.sync_clock_pin;

   always_comb begin
      r_next = r_reg;
      if (reload) begin
         r_next.cnt = divisor;
         r_next.phase = 4'h0;
      end else if (baud) begin
         r_next.cnt = divisor;
         r_next.phase = (r_reg.phase >= last) ? 4'h0 : r_reg.phase + 4'h1;
      end else begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
      // The clock rises together with each new bit, so the far end samples on the fall.
      r_next.sync_clock_pin = (r_next.phase == 4'h0);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule : tx_bit_clock

// ---- core/tx_parity.sv ----
`timescale 1ns/1ps
module tx_parity
   import serial_tx_pkg::*;
(
   // Character and format
   input wire logic [CHAR_W-1:0] data,
   input wire logic [2:0] size,
   input wire logic odd,
   // Result
   output logic parity
);

   assign parity = (^(data & char_mask(size))) ^ odd;

endmodule : tx_parity

// ---- verif/serial_transmitter_path_sva.sv ----
`timescale 1ns/1ps
module serial_transmitter_path_sva
   import serial_tx_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Register bus
   input wire av_req_t av_req,
   input wire av_rsp_t av_rsp,
   // Interrupts
   input wire logic global_irq_enable,
   input wire logic tx_done_serviced,
   input wire logic irq_buffer_empty,
   input wire logic irq_transmit_done,
   // Pins
   input wire logic xck_in,
   input wire pin_out_t pins
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_req_wait;
      (av_req.read || av_req.write) && av_rsp.waitrequest;
   endsequence
   sequence s_enable_write;
      av_req.write && !av_rsp.waitrequest && av_req.address == OFS_CONTROL_B
         && av_req.writedata[CB_TX_EN];
   endsequence
   sequence s_low_driven;
      pins.txd_oe ##1 (!pins.txd && pins.txd_oe);
   endsequence

   AST_BUS_ONE_WAIT: assert property (s_req_wait |=> !av_rsp.waitrequest)
      else $error("request not answered after one wait cycle");
   AST_BUS_LOW_ONCE: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_ENABLE_TAKES_PIN: assert property (s_enable_write |-> ##[1:3] pins.txd_oe)
      else $error("enabled transmitter does not drive the pin");
   AST_START_DRIVEN: assert property ($fell(pins.txd) |-> s_low_driven)
      else $error("low bit shorter than two clocks or not driven");
   AST_RELEASE_IDLE_HIGH: assert property ($fell(pins.txd_oe) |-> pins.txd && $past(pins.txd, 2))
      else $error("pin released while not idle high");
   AST_BE_IRQ_GATED: assert property (irq_buffer_empty |-> $past(global_irq_enable))
      else $error("buffer empty request without global enable");
   AST_TD_IRQ_GATED: assert property (irq_transmit_done |-> $past(global_irq_enable))
      else $error("transmit done request without global enable");
   AST_TD_SERVICE_CLEARS: assert property (tx_done_serviced && irq_transmit_done |-> ##[1:3] !irq_transmit_done)
      else $error("serviced transmit done request stays up");
   AST_TD_AFTER_STOP: assert property ($rose(irq_transmit_done) |-> pins.txd && $past(pins.txd, 2))
      else $error("transmit done raised inside a frame");
   AST_XCK_MASTER_ONLY: assert property ($rose(pins.sync_clock_pin) |-> pins.xck_oe)
      else $error("sync clock toggles without driving the pin");
   AST_XCK_DATA_EDGE: assert property (pins.xck_oe && $changed(pins.txd) |-> $rose(pins.sync_clock_pin))
      else $error("sync clock does not rise with the data change");
endmodule : serial_transmitter_path_sva

bind serial_transmitter_path serial_transmitter_path_sva serial_transmitter_path_sva_i (
   .clk_sys(clk_sys), .rstn(rstn), .av_req(av_req), .av_rsp(av_rsp),
   .global_irq_enable(global_irq_enable), .tx_done_serviced(tx_done_serviced),
   .irq_buffer_empty(irq_buffer_empty), .irq_transmit_done(irq_transmit_done),
   .xck_in(xck_in), .pins(pins));

// ---- verif/serial_rx_model.sv ----
`timescale 1ns/1ps
module serial_rx_model (
   // Line
   input wire logic clk_sys,
   input wire logic txd,
   // Format
   input wire logic [15:0] period,
   input wire logic [3:0] nbits,
   input wire logic par_on,
   // Capture
   output logic [8:0] char_q,
   output logic par_q,
   output logic stop_q,
   output int frames
);
   int i;
   // Sampling mid-bit from the start edge, so a wrong bit rate corrupts the data.
   initial begin
      frames = 0;
      forever begin
         @(posedge clk_sys iff txd === 1'b1);
         @(posedge clk_sys iff txd === 1'b0);
         repeat (period / 2) @(posedge clk_sys);
         if (txd === 1'b0) begin
            char_q = '0;
            for (i = 0; i < nbits; i++) begin
               repeat (period) @(posedge clk_sys);
               char_q[i] = txd;
            end
            repeat (period) @(posedge clk_sys);
            par_q = txd;
            if (par_on) begin
               repeat (period) @(posedge clk_sys);
            end
            stop_q = txd;
            frames++;
         end
      end
   end
endmodule : serial_rx_model

// ---- verif/serial_transmitter_path_tb.sv ----
`timescale 1ns/1ps
module serial_transmitter_path_tb
   import serial_tx_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   av_req_t av_req = '0;
   av_rsp_t av_rsp;
   logic global_irq_enable = 1'b0;
   logic tx_done_serviced = 1'b0;
   logic irq_buffer_empty;
   logic irq_transmit_done;
   pin_out_t pins;
   logic [15:0] period = 16'h0010;
   logic [3:0] nbits = 4'h8;
   logic par_on = 1'b0;
   logic [8:0] char_q;
   logic par_q;
   logic stop_q;
   logic [DATA_W-1:0] rd;
   logic [1:0] ie = 2'b00;
   logic ds = 1'b0;
   logic xck_in = 1'b0;
   int xck_div = 0;
   int frames;
   int div = 0;
   int mismatches = 0;
   int compares = 0;
   int seed = 7;
   int k;
   int n;
   int n0;
   logic [2:0] sizes [5] = '{SIZE_5, SIZE_6, SIZE_7, SIZE_8, SIZE_9};
   logic [ADDR_W-1:0] rofs [6] = '{OFS_DATA, OFS_STATUS_A, OFS_CONTROL_B, OFS_CONTROL_C,
      OFS_BAUD, 5'h14};
   logic [DATA_W-1:0] rexp [6] = '{32'h0, 32'h1, 32'h0, 32'h3, 32'h0, 32'h0};

   serial_transmitter_path serial_transmitter_path_i (
      .clk_sys(clk_sys), .rstn(rstn), .av_req(av_req), .av_rsp(av_rsp),
      .global_irq_enable(global_irq_enable), .tx_done_serviced(tx_done_serviced),
      .irq_buffer_empty(irq_buffer_empty), .irq_transmit_done(irq_transmit_done),
      .xck_in(xck_in), .pins(pins));
   serial_rx_model serial_rx_model_i (
      .clk_sys(clk_sys), .txd(pins.txd), .period(period), .nbits(nbits), .par_on(par_on),
      .char_q(char_q), .par_q(par_q), .stop_q(stop_q), .frames(frames));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   // Far-end sync clock for slave mode, eight system clocks per period.
   always @(posedge clk_sys) begin
      xck_div <= (xck_div + 1) % 4;
      if (xck_div == 3) xck_in <= ~xck_in;
   end

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   // The request is dropped one edge after acceptance so it is never taken twice.
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      av_req <= '{read: !wr, write: wr, address: a, writedata: d};
      @(posedge clk_sys);
      while (av_rsp.waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rd = av_rsp.readdata;
      av_req <= '0;
      @(posedge clk_sys);
   endtask : bus

   task automatic send(input logic [7:0] cc, input logic [8:0] v);
      logic [8:0] exp;
      logic [31:0] r;
      nbits = (cc[2:0] == SIZE_9) ? 4'h9 : 4'(cc[2:0]) + 4'h5;
      par_on = cc[CC_PAR_EN];
      period = 16'((div + 1) * (cc[CC_SYNC] ? 2 : (ds ? 8 : 16)));
      if (cc[CC_SYNC] && !cc[CC_MASTER]) period = 16'h0008;
      exp = v & 9'((1 << nbits) - 1);
      r = $random(seed);
      bus(1'b1, OFS_BAUD, 32'(div));
      bus(1'b1, OFS_CONTROL_C, {24'h0, cc});
      bus(1'b1, OFS_STATUS_A, {29'h0, ds, 2'b10});
      bus(1'b1, OFS_CONTROL_B, {28'h0, ie, v[8], 1'b1});
      n0 = frames;
      bus(1'b1, OFS_DATA, {r[31:8], v[7:0]});
      for (n = 0; n < 20000 && frames == n0; n++) @(posedge clk_sys);
      check(32'(frames - n0), 32'h1);
      check(32'(char_q), 32'(exp));
      if (par_on) check(32'(par_q), 32'(^exp ^ cc[CC_PAR_ODD]));
      check(32'(stop_q), 32'h1);
      repeat (3 * period) @(posedge clk_sys);
      bus(1'b0, OFS_STATUS_A, '0);
      check(rd & 32'h7, {29'h0, ds, 2'b11});
   endtask : send

   task automatic summarize();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // About five thousand cycles are expected; this allows eight times that.
   initial begin
      #400000;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      check(32'(pins.txd_oe), 32'h0);
      foreach (rofs[i]) begin
         bus(1'b0, rofs[i], '0);
         check(rd, rexp[i]);
      end
      bus(1'b1, OFS_CONTROL_B, 32'h1);
      check(32'({pins.txd_oe, pins.txd}), 32'h3);
      for (k = 0; k < 16; k++) begin
         ds = k[3];
         div = (k % 3 == 2) ? 1 : 0;
         send({2'b00, k[2:0], sizes[k % 5]}, (k == 0) ? 9'h1FF : 9'($random(seed)));
      end
      ds = 1'b0;
      div = 3;
      send(8'h43, 9'($random(seed)));
      check(32'(pins.xck_oe), 32'h0);
      send(8'hD3, 9'($random(seed)));
      check(32'(pins.xck_oe), 32'h1);
      div = 0;
      ie = 2'b11;
      send(8'h03, 9'h0A5);
      global_irq_enable <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(32'({irq_buffer_empty, irq_transmit_done}), 32'h3);
      tx_done_serviced <= 1'b1;
      @(posedge clk_sys);
      tx_done_serviced <= 1'b0;
      bus(1'b0, OFS_STATUS_A, '0);
      check(32'({irq_transmit_done, rd[SA_TX_DONE]}), 32'h0);
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(32'(irq_buffer_empty), 32'h0);
      n0 = frames;
      bus(1'b1, OFS_DATA, 32'h0000_0055);
      for (n = 0; n < 100 && pins.txd !== 1'b0; n++) @(posedge clk_sys);
      check(32'(pins.txd), 32'h0);
      bus(1'b1, OFS_DATA, 32'h0000_00C3);
      bus(1'b0, OFS_STATUS_A, '0);
      check(rd & 32'h3, 32'h0);
      bus(1'b1, OFS_CONTROL_B, 32'h0);
      for (n = 0; n < 400 && frames < n0 + 2; n++) @(posedge clk_sys);
      check(32'(frames - n0), 32'h2);
      check(32'(char_q), 32'h0C3);
      repeat (48) @(posedge clk_sys);
      check(32'(pins.txd_oe), 32'h0);
      n0 = frames;
      bus(1'b1, OFS_DATA, 32'h0000_0011);
      repeat (400) @(posedge clk_sys);
      check(32'(frames - n0), 32'h0);
      summarize();
   end
endmodule : serial_transmitter_path_tb
